// >>> logic/system_watchdog_consts.svh
/*
  Constants for the board watchdog: bus addresses, field positions,
  reset values and timing counts.
  Assumes a 10 MHz system clock.
*/
`ifndef SYSTEM_WATCHDOG_CONSTS_SVH
`define SYSTEM_WATCHDOG_CONSTS_SVH

// ****************************************
// bus addresses and values
// ****************************************
`define SYSWD_CTRL_ADDR 32'h23800000
`define SYSWD_FEED_ADDR 32'h23C00000
`define SYSWD_FEED_VALUE 8'h05
`define SYSWD_CODE_LSB 0
`define SYSWD_CODE_MSB 2
`define SYSWD_CODE_RESET 3'h0

// ****************************************
// timing
// ****************************************
`define SYSWD_CLK_HZ 10000000
`define SYSWD_BASE_MS 250
`define SYSWD_WINDOW_US 30
// longest time: rounds down
`define SYSWD_WINDOW_CYCLES ((`SYSWD_WINDOW_US * `SYSWD_CLK_HZ) / 1000000)
`define SYSWD_TICK_CYCLES (`SYSWD_BASE_MS * (`SYSWD_CLK_HZ / 1000))
`define SYSWD_RST_PULSE 16

`endif

// >>> logic/system_watchdog_pkg.sv
/*
  Types and the timeout decode for the board watchdog.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package system_watchdog_pkg;

  typedef logic [2:0] tcode_t;
  typedef logic [5:0] tick_count_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FIRE} wd_state_t;

  // timeout in 250 ms ticks; zero means no timeout
  function automatic tick_count_t tick_limit(input tcode_t code);
    case (code)
      3'h1: tick_limit = 6'h01;
      3'h2: tick_limit = 6'h02;
      3'h3: tick_limit = 6'h04;
      3'h5: tick_limit = 6'h08;
      3'h6: tick_limit = 6'h10;
      3'h7: tick_limit = 6'h20;
      default: tick_limit = 6'h00;
    endcase
  endfunction

endpackage

// >>> logic/watchdog_prescaler.sv
/*
  Prescaler: one-cycle tick every TICK_CYCLES clocks, restarted by clear.
  Assumes clear comes from logic on the same clock.
*/
`timescale 1ns/1ps
`include "system_watchdog_consts.svh"

module watchdog_prescaler #(
  parameter int TICK_CYCLES = `SYSWD_TICK_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_clear,
  output logic o_tick
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt_r;
  logic tick_r;

  // ****************************************
  // divider
  // ****************************************
  // clock derived ticks
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (i_clear) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
    end
  end

  assign o_tick = tick_r;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  chk_tick_single: assert property (tick_r |=> !tick_r)
    else $error("prescaler tick longer than one cycle");

endmodule // watchdog_prescaler

// >>> logic/system_watchdog.sv
/*
  Board watchdog: control and feed registers on the processor bus,
  timeout counter, and a system reset pulse on timeout.
  Assumes bus strobes come from logic on i_clk_sys, one access per strobe.
*/
`timescale 1ns/1ps
`include "system_watchdog_consts.svh"

module system_watchdog
  import system_watchdog_pkg::*;
#(
  parameter int TICK_CYCLES = `SYSWD_TICK_CYCLES,
  parameter int WINDOW_CYCLES = `SYSWD_WINDOW_CYCLES,
  parameter int PULSE_CYCLES = `SYSWD_RST_PULSE
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [31:0] i_bus_addr,
  input wire logic i_bus_wr,
  input wire logic i_bus_rd,
  input wire logic [7:0] i_bus_wdata,
  output logic [7:0] o_bus_rdata,
  output logic o_sys_reset,
  output logic o_wd_enabled
);

  logic ctrl_hit;
  logic feed_hit;
  logic feed_ok;
  logic ctrl_wr;
  logic ctrl_ok;
  logic win_open;
  logic enabled;
  logic tick;
  logic timeout;
  logic pre_clear;
  tick_count_t limit;
  tcode_t code_r;
  tick_count_t tick_cnt_r;
  logic [15:0] win_cnt_r;
  logic [7:0] pulse_cnt_r;
  wd_state_t state_r;
  wd_state_t state_nxt;
  logic [7:0] rdata_r;
  logic sys_reset_r;
  logic enabled_r;

  // ****************************************
  // bus decode
  // ****************************************
  assign ctrl_hit = (i_bus_addr == `SYSWD_CTRL_ADDR);
  assign feed_hit = (i_bus_addr == `SYSWD_FEED_ADDR);
  assign feed_ok = i_bus_wr && feed_hit && (i_bus_wdata == `SYSWD_FEED_VALUE);
  assign ctrl_wr = i_bus_wr && ctrl_hit;
  assign win_open = (win_cnt_r != 16'h0000);
  assign ctrl_ok = ctrl_wr && win_open;
  assign limit = tick_limit(code_r);
  assign enabled = (limit != 6'h00);

  // ****************************************
  // load window
  // ****************************************
  // window opened by a feed
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      win_cnt_r <= 16'h0000;
    end else if (feed_ok) begin
      win_cnt_r <= 16'(WINDOW_CYCLES);
    end else if (ctrl_ok) begin
      // one load per feed keeps a runaway loop from reprogramming
      win_cnt_r <= 16'h0000;
    end else if (win_open) begin
      win_cnt_r <= win_cnt_r - 16'h0001;
    end
  end

  // ****************************************
  // control register
  // ****************************************
  // reset to disabled code
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      code_r <= `SYSWD_CODE_RESET;
    end else if (ctrl_ok) begin
      code_r <= i_bus_wdata[`SYSWD_CODE_MSB:`SYSWD_CODE_LSB];
    end
  end

  // ****************************************
  // timeout counter
  // ****************************************
  assign pre_clear = feed_ok || ctrl_ok || (state_r != ST_RUN);

  watchdog_prescaler #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_prescaler (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_clear(pre_clear),
    .o_tick(tick)
  );

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_r <= 6'h00;
    end else if (pre_clear) begin
      tick_cnt_r <= 6'h00;
    end else if (tick) begin
      tick_cnt_r <= tick_cnt_r + 6'h01;
    end
  end

  // a feed in the same cycle wins
  assign timeout = (state_r == ST_RUN) && tick && !feed_ok && !ctrl_ok &&
                   ((tick_cnt_r + 6'h01) == limit);

  // ****************************************
  // state machine
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (enabled) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enabled) begin
          state_nxt = ST_IDLE;
        end else if (timeout) begin
          state_nxt = ST_FIRE;
        end
      end
      ST_FIRE: begin
        if (pulse_cnt_r == 8'(PULSE_CYCLES - 1)) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pulse_cnt_r <= 8'h00;
    end else if (state_r == ST_FIRE) begin
      pulse_cnt_r <= pulse_cnt_r + 8'h01;
    end else begin
      pulse_cnt_r <= 8'h00;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // reset pulse while firing
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sys_reset_r <= 1'b0;
      enabled_r <= 1'b0;
    end else begin
      sys_reset_r <= (state_nxt == ST_FIRE);
      enabled_r <= enabled;
    end
  end

  // feed register is write only and reads as zero
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_r <= 8'h00;
    end else if (i_bus_rd && ctrl_hit) begin
      rdata_r <= {5'h00, code_r};
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign o_bus_rdata = rdata_r;
  assign o_sys_reset = sys_reset_r;
  assign o_wd_enabled = enabled_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  sequence s_fed;
    feed_ok;
  endsequence

  sequence s_quiet3;
    (!feed_ok && !ctrl_wr) [*3];
  endsequence

  chk_timeout_reset: assert property (timeout |=> o_sys_reset [*2])
    else $error("timeout did not assert system reset");
  chk_feed_clears: assert property (
    s_fed and (state_r == ST_RUN) |=> tick_cnt_r == 6'h00)
    else $error("feed did not clear counter");
  chk_feed_saves: assert property (
    s_fed and (state_r == ST_RUN) |=> !o_sys_reset [*2])
    else $error("reset followed a timely feed");
  chk_enable_runs: assert property (
    enabled && state_r == ST_IDLE |=> state_r == ST_RUN)
    else $error("enabled watchdog did not start");
  chk_code_decode: assert property (
    code_r == 3'h7 |-> limit == 6'h20 && enabled)
    else $error("8 s code decoded wrongly");
  chk_disabled_quiet: assert property (
    (code_r == 3'h0 || code_r == 3'h4) && state_r != ST_FIRE
    |=> !o_sys_reset)
    else $error("reset while disabled");
  chk_window_load: assert property (
    s_fed ##1 s_quiet3 ##1 ctrl_wr
    |=> code_r == $past(i_bus_wdata[2:0]))
    else $error("control write in window not taken");
  chk_stale_ignored: assert property (
    ctrl_wr && !win_open |=> $stable(code_r))
    else $error("control write outside window took effect");
  chk_bad_feed: assert property (
    i_bus_wr && feed_hit && i_bus_wdata != `SYSWD_FEED_VALUE && !win_open
    |=> !win_open)
    else $error("wrong feed value opened window");
  chk_reset_code: assert property ($rose(i_reset_n) |-> code_r == 3'h0)
    else $error("control not disabled after reset");

endmodule // system_watchdog

// >>> testbench/board_watchdog_timer_tb.sv
/*
  Self-checking bench for system_watchdog: feeds, control loads, timeouts.
  Assumes a 10 MHz clock and a prescaler shortened to 20 cycles a tick.
*/
`timescale 1ns/1ps
`include "system_watchdog_consts.svh"
module board_watchdog_timer_tb;
  localparam int TK = 20;
  localparam int PW = 16;
  localparam int WN = 8;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic [31:0] i_bus_addr = 32'h0;
  logic i_bus_wr = 1'b0;
  logic i_bus_rd = 1'b0;
  logic [7:0] i_bus_wdata = 8'h00;
  logic [7:0] o_bus_rdata;
  logic o_sys_reset;
  logic o_wd_enabled;
  int n_errors = 0;
  int total_checks = 0;
  int hits, n, s;
  logic [7:0] d;
  logic [2:0] c;
  logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};

  system_watchdog #(.TICK_CYCLES(TK), .WINDOW_CYCLES(WN),
    .PULSE_CYCLES(PW)) i_system_watchdog (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_bus_addr(i_bus_addr),
    .i_bus_wr(i_bus_wr),
    .i_bus_rd(i_bus_rd),
    .i_bus_wdata(i_bus_wdata),
    .o_bus_rdata(o_bus_rdata),
    .o_sys_reset(o_sys_reset),
    .o_wd_enabled(o_wd_enabled)
  );

  initial begin
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  // ****************************************
  // helpers
  // ****************************************
  // ticks of 250 ms: doubling per code, code 4 skipped
  function automatic int ticks(input logic [2:0] cd);
    return 1 << (cd - 1 - (cd > 4));
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // cycle counts get a little slack for pipeline stages
  task automatic chkn(input int got, input int exp);
    total_checks++;
    if (got > exp + 3 || got < exp - 3) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    @(negedge i_clk_sys);
    i_bus_addr = a;
    i_bus_wdata = v;
    i_bus_wr = 1'b1;
    @(negedge i_clk_sys);
    i_bus_wr = 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    @(negedge i_clk_sys);
    i_bus_addr = a;
    i_bus_rd = 1'b1;
    @(negedge i_clk_sys);
    i_bus_rd = 1'b0;
    chk8(o_bus_rdata, e);
  endtask

  task automatic idle(input int k);
    repeat (k) begin
      @(negedge i_clk_sys);
      if (o_sys_reset === 1'b1) hits++;
    end
  endtask

  task automatic load(input logic [2:0] cd);
    wr(`SYSWD_FEED_ADDR, 8'h05);
    d = $urandom;
    wr(`SYSWD_CTRL_ADDR, {d[7:3], cd});
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(45));
    repeat (4) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    hits = 0;
    rd(`SYSWD_CTRL_ADDR, 8'h00);
    wr(`SYSWD_CTRL_ADDR, 8'h01);
    rd(`SYSWD_CTRL_ADDR, 8'h00);
    d = $urandom;
    wr(`SYSWD_FEED_ADDR, d | 8'h08);
    wr(`SYSWD_CTRL_ADDR, 8'h01);
    rd(`SYSWD_CTRL_ADDR, 8'h00);
    wr(`SYSWD_FEED_ADDR, 8'h05);
    idle(10);
    wr(`SYSWD_CTRL_ADDR, 8'h01);
    rd(`SYSWD_CTRL_ADDR, 8'h00);
    // three quiet cycles between feed and load
    wr(`SYSWD_FEED_ADDR, 8'h05);
    idle(2);
    wr(`SYSWD_CTRL_ADDR, 8'h04);
    rd(`SYSWD_CTRL_ADDR, 8'h04);
    // last cycle of the window still loads
    wr(`SYSWD_FEED_ADDR, 8'h05);
    idle(WN - 2);
    wr(`SYSWD_CTRL_ADDR, 8'h00);
    rd(`SYSWD_CTRL_ADDR, 8'h00);
    // one cycle later the load is refused
    wr(`SYSWD_FEED_ADDR, 8'h05);
    idle(WN - 1);
    wr(`SYSWD_CTRL_ADDR, 8'h04);
    rd(`SYSWD_CTRL_ADDR, 8'h00);
    chk8(8'(hits), 8'h00);
    s = $urandom % 6;
    for (int k = 0; k < 6; k++) begin
      c = codes[(s + k) % 6];
      load(c);
      rd(`SYSWD_CTRL_ADDR, {5'h00, c});
      chk8({7'h00, o_wd_enabled}, 8'h01);
      n = 2;
      while (o_sys_reset !== 1'b1 && n < ticks(c) * TK + 20) begin
        @(negedge i_clk_sys);
        n++;
      end
      chkn(n, ticks(c) * TK);
      n = 0;
      while (o_sys_reset === 1'b1 && n < 100) begin
        @(negedge i_clk_sys);
        n++;
      end
      chk8(8'(n), 8'(PW));
    end
    i_reset_n = 1'b0;
    @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    rd(`SYSWD_CTRL_ADDR, 8'h00);
    load(3'h2);
    hits = 0;
    // feed gaps stay under the 40-cycle period
    repeat (8) begin
      idle(5 + $urandom % 25);
      wr(`SYSWD_FEED_ADDR, 8'h05);
    end
    chk8(8'(hits), 8'h00);
    repeat (6) begin
      idle(8);
      d = $urandom;
      wr(`SYSWD_FEED_ADDR, d | 8'h08);
    end
    chk8(8'(hits != 0), 8'h01);
    idle(20);
    load(3'h0);
    hits = 0;
    idle(700);
    chk8({7'h00, o_wd_enabled}, 8'h00);
    load(3'h4);
    rd(`SYSWD_CTRL_ADDR, 8'h04);
    rd(`SYSWD_CTRL_ADDR + 32'h4, 8'h00);
    idle(700);
    chk8(8'(hits), 8'h00);
    close_out();
  end

  // about six times the expected length of the run
  initial begin
    #2000000;
    n_errors++;
    close_out();
  end
endmodule // board_watchdog_timer_tb
